// ===== spipc_core.sv
// spipc_core.sv: serial port control block with pins, low-power and
// break handling, reached over a classic wishbone slave.
// assumes the system drives wait, stop and break states on mclk and that
// the pin pads resolve output enables into the wires.
//
// Behaviour
// - module runs in wait; registers unreachable then
// - enabled requests wake cpu; overrun needs error enable
// - stop freezes module, keeps registers, resumes later
// - reset leaving stop aborts transfer, resets all
// - break clear enabled: clears during break stick
// - break protected: accesses clear no flag, second step later
// - protected break data write ignored entirely
// - miso driven only as selected slave
// - enabled module owns miso, mosi, clock directions
// - master drives clock, slave receives; eight cycles
// - deselected slave ignores clock edges
// - slave select always input in slave role
// - master select pin gpio unless detect enabled
// - receive enable gates receive-full requests
// - master select bit, reset to master
// - polarity sets idle clock level, reset clear
// - phase bit selects timing, reset to one
// - open-drain select disables pullups on pins
// - unit enable; clearing gives partial reset
// - transmit enable gates empty requests; set on load
// - transmit-empty cleared only by data write
// - master detect enabled: select low sets fault
`timescale 1ns/1ps
`include "spipc_cfg.svh"

module spipc_core
  import spipc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // system states
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  input  wire logic        break_active,
  // serial pins
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe,
  input  wire logic        ss_n_i,
  // port ownership and requests
  output logic             pins_owned,
  output logic             ss_pin_used,
  output logic             pullup_en,
  output logic             rx_err_irq,
  output logic             tx_irq,
  output logic             wake_req
);

  // ==========================================================
  // helpers
  function automatic logic [6:0] half_period(input logic [1:0] sel);
    logic [6:0] h;
    h = `SPIPC_HALF_BD0;
    if (sel == 2'h1) begin
      h = `SPIPC_HALF_BD1;
    end else if (sel == 2'h2) begin
      h = `SPIPC_HALF_BD2;
    end else if (sel == 2'h3) begin
      h = `SPIPC_HALF_BD3;
    end
    return h;
  endfunction

  spipc_state_t q;
  spipc_state_t d;

  // ==========================================================
  // next state
  always_comb begin
    logic       en;
    logic       mstr;
    logic       clock_phase_select;
    logic       guard;
    logic       acc;
    logic       wr;
    logic       rd;
    logic       edge_ev;
    logic       lead;
    logic       sample;
    logic       shift;
    logic       done;
    logic       abort;
    logic       in_bit;
    logic       s_ss;
    logic       s_sclk;
    logic       set_select_conflict_flag;
    logic       drive;
    logic [3:0] a;
    en       = 1'b0;
    mstr     = 1'b0;
    clock_phase_select     = 1'b0;
    guard    = 1'b0;
    acc      = 1'b0;
    wr       = 1'b0;
    rd       = 1'b0;
    edge_ev  = 1'b0;
    lead     = 1'b0;
    sample   = 1'b0;
    shift    = 1'b0;
    done     = 1'b0;
    abort    = 1'b0;
    in_bit   = 1'b0;
    s_ss     = 1'b0;
    s_sclk   = 1'b0;
    set_select_conflict_flag = 1'b0;
    drive    = 1'b0;
    a        = 4'h0;
    d = q;

    // pins pass two flip-flops before anything reads them
    d.sy_sclk = {q.sy_sclk[0], sclk_i};
    d.sy_mosi = {q.sy_mosi[0], mosi_i};
    d.sy_miso = {q.sy_miso[0], miso_i};
    d.sy_ss   = {q.sy_ss[0], ss_n_i};
    s_ss      = q.sy_ss[1];
    s_sclk    = q.sy_sclk[1];
    d.prev_sclk = s_sclk;
    d.prev_ss   = s_ss;

    en   = q.ctrl[`SPIPC_C_EN];
    mstr = q.ctrl[`SPIPC_C_MSTR];
    clock_phase_select = q.ctrl[`SPIPC_C_CLOCK_PHASE_SELECT];
    // protected break: no access may clear a flag
    guard = break_active && !q.break_clear_enable;

    // ==========================================================
    // wishbone access, one wait state then ack
    d.ack = 1'b0;
    d.dat = 8'h00;
    a = wb_adr_i[3:0];
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      d.ack = 1'b1;
      acc = !wait_mode;
      wr  = acc && wb_we_i && wb_sel_i[0];
      rd  = acc && !wb_we_i;
    end

    if (rd) begin
      if (a == `SPIPC_ADR_CONTROL) begin
        d.dat = q.ctrl;
      end else if (a == `SPIPC_ADR_STATUS) begin
        d.dat = {q.rx_full, q.err_ie, q.ovr, q.select_conflict_flag, q.tx_empty, q.cde,
                 q.baud};
        if (!guard) begin
          // first step of the two-step clears
          d.arm_rx   = q.rx_full || q.ovr;
          d.arm_select_conflict_flag = q.select_conflict_flag;
        end
      end else if (a == `SPIPC_ADR_DATA) begin
        d.dat = q.rx_data;
        if (!guard && q.arm_rx) begin
          d.rx_full = 1'b0;
          d.ovr     = 1'b0;
          d.arm_rx  = 1'b0;
        end
      end else if (a == `SPIPC_ADR_BREAK) begin
        d.dat = {7'h00, q.break_clear_enable};
      end
    end

    if (wr) begin
      if (a == `SPIPC_ADR_CONTROL) begin
        d.ctrl = wb_dat_i[7:0];
        if (!guard && q.arm_select_conflict_flag) begin
          d.select_conflict_flag     = 1'b0;
          d.arm_select_conflict_flag = 1'b0;
        end
      end else if (a == `SPIPC_ADR_STATUS) begin
        d.err_ie = wb_dat_i[`SPIPC_S_ERROR_IRQ_ENABLE];
        d.cde    = wb_dat_i[`SPIPC_S_CDE];
        d.baud   = wb_dat_i[1:0];
      end else if (a == `SPIPC_ADR_DATA) begin
        // a protected break leaves buffer and flag untouched
        if (!guard) begin
          d.tx_buf   = wb_dat_i[7:0];
          d.tx_empty = 1'b0;
        end
      end else if (a == `SPIPC_ADR_BREAK) begin
        d.break_clear_enable = wb_dat_i[0];
      end
    end

    // ==========================================================
    // shift engine, frozen in stop without touching registers
    if (en && !stop_mode) begin
      if (mstr) begin
        if (q.busy) begin
          if (q.div_cnt == half_period(q.baud) - 7'h01) begin
            d.div_cnt  = 7'h00;
            d.sclk_lvl = !q.sclk_lvl;
            edge_ev    = 1'b1;
          end else begin
            d.div_cnt = q.div_cnt + 7'h01;
          end
        end
        in_bit = q.sy_miso[1];
      end else begin
        // a deselected slave drops the byte and its edges
        if (s_ss) begin
          if (q.xfer && q.cde) begin
            set_select_conflict_flag = 1'b1;
          end
          d.xfer     = 1'b0;
          d.edge_cnt = 5'h00;
        end else begin
          if (!clock_phase_select && q.prev_ss) begin
            d.xfer = 1'b1;
          end
          edge_ev = s_sclk != q.prev_sclk;
        end
        in_bit = q.sy_mosi[1];
      end

      if (edge_ev) begin
        lead   = !q.edge_cnt[0];
        sample = clock_phase_select ? !lead : lead;
        shift  = clock_phase_select ? (lead && q.edge_cnt != 5'h00) : !lead;
        d.edge_cnt = q.edge_cnt + 5'h01;
        if (!mstr) begin
          d.xfer = 1'b1;
        end
        if (sample) begin
          d.rx_sh = {q.rx_sh[6:0], in_bit};
        end
        if (shift) begin
          d.tx_sh = {q.tx_sh[6:0], 1'b0};
        end
        // a byte is eight full clock cycles
        if (d.edge_cnt == `SPIPC_EDGES_PER_BYTE) begin
          done       = 1'b1;
          d.edge_cnt = 5'h00;
          d.busy     = 1'b0;
          d.xfer     = 1'b0;
        end
      end

      if (done) begin
        if (q.rx_full) begin
          d.ovr = 1'b1;
        end else begin
          d.rx_data = sample ? {q.rx_sh[6:0], in_bit} : q.rx_sh;
          d.rx_full = 1'b1;
        end
      end

      // load the shifter from the transmit buffer when idle
      // only a buffer written on an earlier edge is loaded, else the
      // old byte would go out and the new one would be lost
      if ((done || (!q.busy && !q.xfer && q.edge_cnt == 5'h00))
          && !q.tx_empty) begin
        d.tx_sh    = q.tx_buf;
        d.tx_empty = 1'b1;
        d.busy     = mstr;
        d.div_cnt  = 7'h00;
      end

      // another master pulling select low
      if (mstr && q.cde && !s_ss) begin
        set_select_conflict_flag = 1'b1;
        abort    = 1'b1;
        d.ctrl[`SPIPC_C_EN] = 1'b0;
      end
    end

    if (set_select_conflict_flag) begin
      d.select_conflict_flag     = 1'b1;
      d.arm_select_conflict_flag = 1'b0;
    end

    // ==========================================================
    // partial reset while disabled
    if (!d.ctrl[`SPIPC_C_EN] || abort) begin
      d.tx_empty = 1'b1;
      d.busy     = 1'b0;
      d.xfer     = 1'b0;
      d.edge_cnt = 5'h00;
      d.div_cnt  = 7'h00;
      d.tx_sh    = 8'h00;
      d.rx_sh    = 8'h00;
    end
    if (!d.busy) begin
      d.sclk_lvl = d.ctrl[`SPIPC_C_CLOCK_IDLE_POLARITY];
    end

    // ==========================================================
    // pin ownership and drive
    en   = d.ctrl[`SPIPC_C_EN];
    mstr = d.ctrl[`SPIPC_C_MSTR];
    d.owned   = en;
    d.ss_used = en && (!mstr || d.cde);
    d.pullup_en = !d.ctrl[`SPIPC_C_ODRN];
    d.sclk_o = d.sclk_lvl;
    d.mosi_o = d.tx_sh[7];
    d.miso_o = d.tx_sh[7];
    drive = en && mstr;
    d.sclk_oe = drive && (d.pullup_en || !d.sclk_lvl);
    d.mosi_oe = drive && (d.pullup_en || !d.tx_sh[7]);
    drive = en && !mstr && !s_ss;
    d.miso_oe = drive && (d.pullup_en || !d.tx_sh[7]);
    if (!d.pullup_en) begin
      d.sclk_o = 1'b0;
      d.mosi_o = 1'b0;
      d.miso_o = 1'b0;
    end

    // ==========================================================
    // interrupt requests and wake
    d.rx_irq = (d.rx_full && d.ctrl[`SPIPC_C_RXIE])
               || (d.err_ie && (d.ovr || d.select_conflict_flag));
    d.tx_irq = d.tx_empty && d.ctrl[`SPIPC_C_TXIE] && en;
    d.wake   = wait_mode && (d.rx_irq || d.tx_irq);
  end

  // ==========================================================
  // state register; a reset out of stop returns everything to its reset value
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.ctrl     <= `SPIPC_CTRL_RST;
      q.tx_empty <= 1'b1;
      q.pullup_en <= 1'b1;
      q.sy_sclk  <= 2'h0;
      q.sy_ss    <= 2'h3;
      q.prev_ss  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign wb_dat_o    = {24'h000000, q.dat};
  assign wb_ack_o    = q.ack;
  assign sclk_o      = q.sclk_o;
  assign sclk_oe     = q.sclk_oe;
  assign mosi_o      = q.mosi_o;
  assign mosi_oe     = q.mosi_oe;
  assign miso_o      = q.miso_o;
  assign miso_oe     = q.miso_oe;
  assign pins_owned  = q.owned;
  assign ss_pin_used = q.ss_used;
  assign pullup_en   = q.pullup_en;
  assign rx_err_irq  = q.rx_irq;
  assign tx_irq      = q.tx_irq;
  assign wake_req    = q.wake;

endmodule

// ===== spipc_cfg.svh
// spipc_cfg.svh: offsets, field positions, reset values and counts for
// the serial port control block.
// assumes word-aligned classic wishbone access with 8-bit registers.
`ifndef SPIPC_CFG_SVH
`define SPIPC_CFG_SVH

// ==========================================================
// register byte offsets
`define SPIPC_ADR_CONTROL 4'h0
`define SPIPC_ADR_STATUS 4'h4
`define SPIPC_ADR_DATA 4'h8
`define SPIPC_ADR_BREAK 4'hc

// ==========================================================
// serial_control fields
`define SPIPC_C_RXIE 7
`define SPIPC_C_MSTR 5
`define SPIPC_C_CLOCK_IDLE_POLARITY 4
`define SPIPC_C_CLOCK_PHASE_SELECT 3
`define SPIPC_C_ODRN 2
`define SPIPC_C_EN 1
`define SPIPC_C_TXIE 0
`define SPIPC_CTRL_RST 8'h28

// ==========================================================
// status_and_control fields
`define SPIPC_S_RXF 7
`define SPIPC_S_ERROR_IRQ_ENABLE 6
`define SPIPC_S_OVR 5
`define SPIPC_S_SELECT_CONFLICT_FLAG 4
`define SPIPC_S_TXE 3
`define SPIPC_S_CDE 2

// ==========================================================
// transfer counts
`define SPIPC_EDGES_PER_BYTE 5'h10
`define SPIPC_HALF_BD0 7'h01
`define SPIPC_HALF_BD1 7'h04
`define SPIPC_HALF_BD2 7'h10
`define SPIPC_HALF_BD3 7'h40

`endif

// ===== spipc_pkg.sv
// spipc_pkg.sv: state type of the serial port control block.
// assumes spipc_cfg.svh for all numeric constants.
package spipc_pkg;

  // ==========================================================
  // whole block state, registered in one process
  typedef struct packed {
    logic [7:0] ctrl;
    logic       break_clear_enable;
    logic       err_ie;
    logic       cde;
    logic [1:0] baud;
    logic       rx_full;
    logic       ovr;
    logic       select_conflict_flag;
    logic       tx_empty;
    logic [7:0] tx_buf;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic       busy;
    logic       xfer;
    logic [4:0] edge_cnt;
    logic [6:0] div_cnt;
    logic       sclk_lvl;
    logic       arm_rx;
    logic       arm_select_conflict_flag;
    logic [1:0] sy_sclk;
    logic [1:0] sy_mosi;
    logic [1:0] sy_miso;
    logic [1:0] sy_ss;
    logic       prev_sclk;
    logic       prev_ss;
    logic       ack;
    logic [7:0] dat;
    logic       sclk_o;
    logic       sclk_oe;
    logic       mosi_o;
    logic       mosi_oe;
    logic       miso_o;
    logic       miso_oe;
    logic       owned;
    logic       ss_used;
    logic       pullup_en;
    logic       rx_irq;
    logic       tx_irq;
    logic       wake;
  } spipc_state_t;

endpackage

// ===== spipc_core_checker.sv
// spipc_core_checker.sv: port-level assertions for spipc_core.
// assumes binding onto spipc_core; all signals on mclk, reset rst.
`timescale 1ns/1ps
module spipc_core_checker (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // states and pins
  input wire logic        wait_mode,
  input wire logic        ss_n_i,
  input wire logic        sclk_oe,
  input wire logic        mosi_o,
  input wire logic        mosi_oe,
  input wire logic        miso_oe,
  input wire logic        pins_owned,
  input wire logic        ss_pin_used,
  input wire logic        pullup_en,
  input wire logic        rx_err_irq,
  input wire logic        tx_irq,
  input wire logic        wake_req
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
  a_wait_blank_read: assert property (wb_ack_o && $past(wait_mode) |-> wb_dat_o == 32'h0) else $error("wait read");
  a_wake_follows_irq: assert property (wake_req == ($past(wait_mode) && (rx_err_irq || tx_irq))) else $error("wake wrong");
  // sync lag plus register stage stays under six cycles
  a_miso_deselected: assert property (ss_n_i [*6] |-> !miso_oe) else $error("miso driven");
  a_sclk_when_owned: assert property (sclk_oe |-> pins_owned) else $error("clock driven");
  a_data_when_owned: assert property (mosi_oe || miso_oe |-> pins_owned) else $error("data driven");
  a_open_drain_low: assert property (mosi_oe && !pullup_en |-> !mosi_o) else $error("high driven");
  a_select_when_owned: assert property (ss_pin_used |-> pins_owned) else $error("select used");
  a_tx_irq_gated: assert property (tx_irq |-> pins_owned) else $error("tx irq ungated");
  c_wake: cover property (wake_req);
  c_slave_out: cover property (miso_oe);
  c_rx_irq: cover property (rx_err_irq);
  c_tx_irq: cover property (tx_irq && !wait_mode);
endmodule

// ===== spipc_peer.sv
// spipc_peer.sv: behavioural far-end slave, polarity 0, phase 1.
// assumes the bench drives its select and resolves the shared wires.
`timescale 1ns/1ps
module spipc_peer (
  // link
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  output logic            miso,
  // user side
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte
);
  // ==========================================================
  // shifter
  logic [7:0] sh;
  logic       bit_q = 1'b0;
  // select stays low across the byte, as phase 1 allows
  always @(negedge ss_n) sh = tx_byte;
  // launch on the rising edge, sample on the falling one
  always @(posedge sclk) if (!ss_n) begin
    bit_q = sh[7];
    sh = {sh[6:0], 1'b0};
  end
  always @(negedge sclk) if (!ss_n) rx_byte = {rx_byte[6:0], mosi};
  // released line shows the inverse of its last bit, never a stale value
  assign miso = ss_n ? ~bit_q : bit_q;
endmodule

// ===== spipc_core_tb.sv
// spipc_core_tb.sv: register-level tests of spipc_core with a peer.
// assumes spipc_cfg.svh offsets and a 20 MHz bus clock.
`timescale 1ns/1ps
`include "spipc_cfg.svh"
module spipc_core_tb;
  localparam logic [3:0] r_ctl = `SPIPC_ADR_CONTROL;
  localparam logic [3:0] r_sts = `SPIPC_ADR_STATUS;
  localparam logic [3:0] r_dat = `SPIPC_ADR_DATA;
  localparam logic [3:0] r_brk = `SPIPC_ADR_BREAK;
  logic        mclk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
  logic [31:0] adr = 0, wdat = 0, dat_o;
  logic [3:0]  sel = 0;
  logic        wait_m = 0, stop_m = 0, brk = 0, sclk_tb = 0, ss_in = 1;
  logic        ps_n = 1, ack, sclk_o, sclk_oe, mosi_o, mosi_oe, sp = 0;
  logic        miso_o, miso_oe, owned, ss_used, pu, rxi, txi, wake, pmiso;
  logic [7:0]  ptx = 8'h3c, prx, q;
  int          errors = 0, total_checks = 0, edges = 0, n;
  wire sclk_w = sclk_oe ? sclk_o : sclk_tb;
  wire mosi_w = mosi_oe ? mosi_o : 1'b1;
  wire miso_w = miso_oe ? miso_o : pmiso;

  // ==========================================================
  // clock, instances, edge counter
  initial forever #25 mclk = ~mclk;
  spipc_core i_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .wait_mode(wait_m),
    .stop_mode(stop_m), .break_active(brk), .sclk_i(sclk_w),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe(miso_oe), .ss_n_i(ss_in), .pins_owned(owned),
    .ss_pin_used(ss_used), .pullup_en(pu), .rx_err_irq(rxi),
    .tx_irq(txi), .wake_req(wake));
  spipc_peer i_peer (.sclk(sclk_w), .mosi(mosi_w), .ss_n(ps_n),
    .miso(pmiso), .tx_byte(ptx), .rx_byte(prx));
  always @(posedge mclk) begin
    if (sclk_o !== sp) edges++;
    sp <= sclk_o;
  end

  // ==========================================================
  // tasks
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [7:0] d, output logic [7:0] r);
    @(posedge mclk);
    cyc <= 1; stb <= 1; we <= w; sel <= 4'h1;
    adr <= {28'h0, a}; wdat <= {24'h0, d};
    // no cycle count is assumed; only the watchdog ends a hung wait
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    r = dat_o[7:0];
    cyc <= 0; stb <= 0;
  endtask
  task chk8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    chk8({7'h0, g}, {7'h0, e});
  endtask
  task clk(input int c);
    repeat (c) @(posedge mclk);
  endtask
  // slave-side link clock, four bus clocks per half period
  task slv(input int c);
    repeat (c) begin
      @(posedge mclk) sclk_tb <= ~sclk_tb;
      repeat (3) @(posedge mclk);
    end
  endtask
  task tend(input string s);
    $display("test %s finished", s);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    test_done;
  end

  // ==========================================================
  // tests
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 0;
    wb(0, r_ctl, 0, q); chk8(q, `SPIPC_CTRL_RST);
    wb(0, r_sts, 0, q); chk8(q, 8'h08);
    chk1(owned, 0);
    chk1(pu, 1);
    wb(1, r_ctl, 8'hdc, q); wb(0, r_ctl, 0, q); chk8(q, 8'hdc);
    wb(0, 4'h2, 0, q); chk8(q, 8'h00);
    tend("reset");
    wb(1, r_sts, 8'h03, q);
    wb(1, r_ctl, 8'hab, q); clk(2);
    chk1(txi, 1);
    chk1(miso_oe, 0);
    chk1(ss_used, 0);
    chk1(sclk_oe, 1);
    chk1(mosi_oe, 1);
    edges = 0; ps_n <= 0;
    wb(1, r_dat, 8'ha5, q);
    n = 0;
    do begin
      wb(0, r_sts, 0, q);
      n++;
    end while (q[7] !== 1'b1 && n < 600);
    chk1(q[7], 1);
    chk1(rxi, 1);
    chk8(8'(edges), {3'h0, `SPIPC_EDGES_PER_BYTE});
    wb(0, r_dat, 0, q); chk8(q, 8'h3c);
    chk8(prx, 8'ha5);
    ps_n <= 1; clk(2);
    chk1(rxi, 0);
    chk1(sclk_o, 0);
    tend("master");
    brk <= 1; edges = 0;
    wb(1, r_dat, 8'h11, q); clk(20);
    chk8(8'(edges), 8'h00);
    wb(0, r_sts, 0, q); chk8(q, 8'h0b);
    chk1(txi, 1);
    brk <= 0;
    wait_m <= 1; clk(2);
    chk1(wake, 1);
    wb(0, r_ctl, 0, q); chk8(q, 8'h00);
    wb(1, r_ctl, 8'h00, q);
    wait_m <= 0;
    wb(0, r_ctl, 0, q); chk8(q, 8'hab);
    stop_m <= 1;
    wb(0, r_ctl, 0, q); chk8(q, 8'hab);
    stop_m <= 0;
    tend("break wait stop");
    wb(1, r_ctl, 8'h0a, q); clk(3);
    chk1(ss_used, 1);
    chk1(miso_oe, 0);
    slv(16);
    wb(0, r_sts, 0, q); chk8(q, 8'h0b);
    @(posedge mclk) ss_in <= 0;
    clk(6);
    chk1(miso_oe, 1);
    wb(1, r_dat, 8'h5a, q);
    clk(2);
    chk1(miso_o, 0);
    slv(16);
    clk(4);
    wb(0, r_sts, 0, q);
    chk8(q, 8'h8b);
    wb(0, r_dat, 0, q);
    chk8(q, 8'hff);
    @(posedge mclk) ss_in <= 1;
    tend("slave");
    wb(1, r_ctl, 8'h2e, q); clk(2);
    chk1(ss_used, 0);
    chk1(pu, 0);
    wb(1, r_sts, 8'h04, q); clk(2);
    chk1(ss_used, 1);
    @(posedge mclk) ss_in <= 0;
    clk(6);
    wb(0, r_sts, 0, q); chk8(q, 8'h1c);
    wb(0, r_ctl, 0, q); chk8(q, 8'h2c);
    chk1(owned, 0);
    @(posedge mclk) ss_in <= 1;
    tend("conflict");
    brk <= 1;
    wb(1, r_ctl, 8'h2c, q);
    wb(0, r_sts, 0, q);
    chk8(q, 8'h1c);
    brk <= 0;
    wb(1, r_ctl, 8'h2c, q);
    wb(0, r_sts, 0, q);
    chk8(q, 8'h0c);
    wb(1, r_brk, 8'h01, q);
    wb(0, r_brk, 0, q);
    chk8(q, 8'h01);
    tend("break clear");
    test_done;
  end
endmodule

bind spipc_core spipc_core_checker i_chk (.mclk(mclk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wait_mode(wait_mode), .ss_n_i(ss_n_i),
  .sclk_oe(sclk_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
  .miso_oe(miso_oe), .pins_owned(pins_owned), .ss_pin_used(ss_pin_used),
  .pullup_en(pullup_en), .rx_err_irq(rx_err_irq), .tx_irq(tx_irq),
  .wake_req(wake_req));
